// [hdl/mac_csr_config.sv]
// Command FIFO and MAC configuration/status register block with PHY management

module csr_cmd_fifo #(
  parameter int WIDTH = 41,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  logic [AW:0] count_next;
  logic push;
  logic pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_ptr_reg];

  always_comb begin
    count_next = count_reg;
    if (push && !pop) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      o_in_ready <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + AW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + AW'(1);
      end
      count_reg <= count_next;
      o_in_ready <= count_next != (AW+1)'(DEPTH);
      o_out_valid <= count_next != '0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= i_in_data;
    end
  end
endmodule // csr_cmd_fifo

module mac_csr_config #(
  parameter int FIFO_DEPTH = 16,
  parameter int DEFER_LIMIT = mac_csr_pkg::DEFER_LINK_CLKS,
  parameter int MDC_HALF = mac_csr_pkg::MDC_HALF_CLKS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_data_port_wr,
  input wire logic [7:0] i_data_port_wdata,
  input wire logic i_data_port_rd,
  output logic [7:0] o_data_port_rdata,
  input wire logic i_addr_port_wr,
  input wire logic [7:0] i_addr_port_wdata,
  input wire logic i_unit_cmd_wr,
  input wire logic [3:0] i_unit_cmd,
  output logic o_unit_cmd_ready,
  output logic o_unit_busy,
  output mac_csr_pkg::mac_config_t o_config,
  input wire mac_csr_pkg::rx_frame_t i_rx_frame,
  input wire logic i_tx_active,
  output logic o_rx_accept,
  output logic o_rx_filter_pass,
  output logic o_rx_strip_pad,
  input wire logic i_link_clk,
  input wire logic i_deferring,
  output logic o_defer_abort,
  output logic [9:0] o_backoff_slots,
  output logic [4:0] o_attempt_limit,
  output logic o_mgmt_clk,
  output logic o_mgmt_data_out,
  output logic o_mgmt_data_oe,
  input wire logic i_mgmt_data_in
);
  mac_csr_pkg::csr_cmd_t cmd_in;
  mac_csr_pkg::csr_cmd_t cmd_out;
  logic [31:0] wr_word_reg;
  logic [7:0] addr_port_reg;
  logic [31:0] rd_word_reg;
  logic fifo_in_valid;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic cmd_take;
  logic mgmt_stall;
  logic [31:0] ctrl_reg;
  logic [31:0] station_high_reg;
  logic [31:0] station_low_reg;
  logic [31:0] hash_upper_reg;
  logic [31:0] hash_lower_reg;
  logic [31:0] mgmt_addr_reg;
  logic [31:0] mgmt_data_reg;
  logic [31:0] read_value;
  logic mgmt_launch;
  logic mgmt_done;

  // Four data bytes arrive most significant first
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_word_reg <= '0;
      addr_port_reg <= '0;
    end else begin
      if (i_data_port_wr) begin
        wr_word_reg <= {wr_word_reg[23:0], i_data_port_wdata};
      end
      if (i_addr_port_wr) begin
        addr_port_reg <= i_addr_port_wdata;
      end
    end
  end

  // Other command codes belong to the buffer unit and are ignored here
  assign fifo_in_valid = i_unit_cmd_wr &&
    (i_unit_cmd == mac_csr_pkg::CMD_CSR_WRITE || i_unit_cmd == mac_csr_pkg::CMD_CSR_READ);
  assign cmd_in.is_write = i_unit_cmd == mac_csr_pkg::CMD_CSR_WRITE;
  assign cmd_in.addr = addr_port_reg;
  assign cmd_in.data = wr_word_reg;

  csr_cmd_fifo #(
    .WIDTH($bits(mac_csr_pkg::csr_cmd_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_cmd_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(fifo_in_valid),
    .i_in_data(cmd_in),
    .o_in_ready(o_unit_cmd_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(cmd_out),
    .i_out_ready(fifo_out_ready)
  );

  // Holding management writes while busy protects the frame in flight
  assign mgmt_stall = cmd_out.is_write && mgmt_addr_reg[mac_csr_pkg::POS_MGMT_BUSY] &&
    (cmd_out.addr == mac_csr_pkg::OFS_MGMT_ADDR || cmd_out.addr == mac_csr_pkg::OFS_MGMT_DATA);
  assign fifo_out_ready = !mgmt_stall;
  assign cmd_take = fifo_out_valid && fifo_out_ready;
  assign mgmt_launch = cmd_take && cmd_out.is_write &&
    cmd_out.addr == mac_csr_pkg::OFS_MGMT_ADDR;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ctrl_reg <= mac_csr_pkg::CTRL_RESET;
      station_high_reg <= mac_csr_pkg::STATION_HIGH_RESET;
      station_low_reg <= mac_csr_pkg::STATION_LOW_RESET;
      hash_upper_reg <= mac_csr_pkg::HASH_RESET;
      hash_lower_reg <= mac_csr_pkg::HASH_RESET;
    end else if (cmd_take && cmd_out.is_write) begin
      case (cmd_out.addr)
        mac_csr_pkg::OFS_MAC_CONTROL: ctrl_reg <= cmd_out.data & mac_csr_pkg::CTRL_MASK;
        mac_csr_pkg::OFS_STATION_HIGH: begin
          station_high_reg <= cmd_out.data & mac_csr_pkg::STATION_HIGH_MASK;
        end
        mac_csr_pkg::OFS_STATION_LOW: station_low_reg <= cmd_out.data;
        mac_csr_pkg::OFS_HASH_UPPER: hash_upper_reg <= cmd_out.data;
        mac_csr_pkg::OFS_HASH_LOWER: hash_lower_reg <= cmd_out.data;
        default: ;
      endcase
    end
  end

  // Busy is set on launch by hardware and cleared only at frame end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mgmt_addr_reg <= '0;
    end else if (mgmt_launch) begin
      mgmt_addr_reg <= (cmd_out.data & mac_csr_pkg::MGMT_ADDR_MASK) |
        (32'h0000_0001 << mac_csr_pkg::POS_MGMT_BUSY);
    end else if (mgmt_done) begin
      mgmt_addr_reg[mac_csr_pkg::POS_MGMT_BUSY] <= 1'b0;
    end
  end

  always_comb begin
    case (cmd_out.addr)
      mac_csr_pkg::OFS_MAC_CONTROL: read_value = ctrl_reg;
      mac_csr_pkg::OFS_STATION_HIGH: read_value = station_high_reg;
      mac_csr_pkg::OFS_STATION_LOW: read_value = station_low_reg;
      mac_csr_pkg::OFS_HASH_UPPER: read_value = hash_upper_reg;
      mac_csr_pkg::OFS_HASH_LOWER: read_value = hash_lower_reg;
      mac_csr_pkg::OFS_MGMT_ADDR: read_value = mgmt_addr_reg;
      mac_csr_pkg::OFS_MGMT_DATA: read_value = mgmt_data_reg;
      default: read_value = '0;
    endcase
  end

  // Unloading shifts the next byte up; MSB is presented first
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      rd_word_reg <= '0;
    end else if (cmd_take && !cmd_out.is_write) begin
      rd_word_reg <= read_value;
    end else if (i_data_port_rd) begin
      rd_word_reg <= {rd_word_reg[23:0], 8'h00};
    end
  end
  assign o_data_port_rdata = rd_word_reg[31:24];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_unit_busy <= 1'b0;
    end else begin
      o_unit_busy <= (fifo_in_valid && o_unit_cmd_ready) || (fifo_out_valid && !cmd_take) ||
        (cmd_take && o_unit_cmd_ready && fifo_in_valid);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_config <= '0;
      o_attempt_limit <= mac_csr_pkg::RETRY_ATTEMPTS_MAX;
    end else begin
      o_config.encoder_decoder_interface <= ctrl_reg[mac_csr_pkg::POS_PORT_TYPE];
      o_config.receive_own_disable <= ctrl_reg[mac_csr_pkg::POS_RX_OWN_DIS];
      o_config.loopback_mode <= ctrl_reg[mac_csr_pkg::POS_LOOPBACK +: 2];
      o_config.full_duplex <= ctrl_reg[mac_csr_pkg::POS_FULL_DUPLEX];
      o_config.late_collision_retry <= ctrl_reg[mac_csr_pkg::POS_LATE_RETRY];
      o_config.transmit_enable <= ctrl_reg[mac_csr_pkg::POS_TX_ENABLE];
      o_config.receive_enable <= ctrl_reg[mac_csr_pkg::POS_RX_ENABLE];
      o_attempt_limit <= ctrl_reg[mac_csr_pkg::POS_RETRY_DIS] ?
        mac_csr_pkg::RETRY_ATTEMPTS_ONE : mac_csr_pkg::RETRY_ATTEMPTS_MAX;
    end
  end

  // Receive address check, one decision per frame strobe
  logic [63:0] hash_table;
  logic is_bcast;
  logic is_group;
  logic hash_hit;
  logic exact_hit;
  logic addr_ok;
  logic frame_pass;
  assign hash_table = {hash_upper_reg, hash_lower_reg};
  assign is_bcast = &i_rx_frame.dest;
  assign is_group = i_rx_frame.dest[40];
  assign hash_hit = hash_table[i_rx_frame.hash_index];
  assign exact_hit = i_rx_frame.dest == {station_high_reg[15:0], station_low_reg};

  always_comb begin
    if (is_bcast) begin
      addr_ok = 1'b1;
    end else if (is_group) begin
      if (ctrl_reg[mac_csr_pkg::POS_PASS_GROUP]) begin
        addr_ok = 1'b1;
      end else if (ctrl_reg[mac_csr_pkg::POS_HASH_EXACT]) begin
        addr_ok = hash_hit;
      end else begin
        addr_ok = exact_hit;
      end
    end else if (ctrl_reg[mac_csr_pkg::POS_HASH_ONLY]) begin
      addr_ok = hash_hit;
    end else begin
      addr_ok = exact_hit;
    end
    if (ctrl_reg[mac_csr_pkg::POS_INVERSE]) begin
      addr_ok = !addr_ok;
    end
    if (ctrl_reg[mac_csr_pkg::POS_ACCEPT_ALL]) begin
      addr_ok = 1'b1;
    end
    if (is_bcast && ctrl_reg[mac_csr_pkg::POS_BCAST_REJECT]) begin
      addr_ok = 1'b0;
    end
    frame_pass = addr_ok && (!i_rx_frame.errored || ctrl_reg[mac_csr_pkg::POS_PASS_ERRORED]);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rx_accept <= 1'b0;
      o_rx_filter_pass <= 1'b0;
      o_rx_strip_pad <= 1'b0;
    end else begin
      o_rx_accept <= i_rx_frame.valid && ctrl_reg[mac_csr_pkg::POS_RX_ENABLE] &&
        !(ctrl_reg[mac_csr_pkg::POS_RX_OWN_DIS] && i_tx_active);
      if (i_rx_frame.valid) begin
        o_rx_filter_pass <= frame_pass;
        o_rx_strip_pad <= ctrl_reg[mac_csr_pkg::POS_PAD_STRIP] &&
          i_rx_frame.length_field < mac_csr_pkg::PAD_MIN_LEN;
      end
    end
  end

  // Link clock sampling; first stage feeds only the second
  logic [2:0] link_sync_reg;
  logic link_level_reg;
  logic link_rise;
  assign link_rise = link_sync_reg[1] && link_sync_reg[2] && !link_level_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      link_sync_reg <= '0;
      link_level_reg <= 1'b0;
    end else begin
      link_sync_reg <= {link_sync_reg[1:0], i_link_clk};
      if (link_sync_reg[1] == link_sync_reg[2]) begin
        link_level_reg <= link_sync_reg[2];
      end
    end
  end

  localparam int SLOT_W = $clog2(mac_csr_pkg::SLOT_LINK_CLKS);
  logic [SLOT_W-1:0] slot_cnt_reg;
  logic [9:0] backoff_cnt_reg;
  logic [9:0] backoff_mask;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      slot_cnt_reg <= '0;
      backoff_cnt_reg <= '0;
    end else if (link_rise) begin
      slot_cnt_reg <= slot_cnt_reg + SLOT_W'(1);
      if (slot_cnt_reg == SLOT_W'(mac_csr_pkg::SLOT_LINK_CLKS - 1)) begin
        backoff_cnt_reg <= backoff_cnt_reg + 10'h001;
      end
    end
  end

  always_comb begin
    case (ctrl_reg[mac_csr_pkg::POS_BACKOFF_LIMIT +: 2])
      mac_csr_pkg::BACKOFF_BITS_10: backoff_mask = 10'h3FF;
      mac_csr_pkg::BACKOFF_BITS_8: backoff_mask = 10'h0FF;
      mac_csr_pkg::BACKOFF_BITS_4: backoff_mask = 10'h00F;
      default: backoff_mask = 10'h001;
    endcase
  end

  // Saturating so a long stall cannot wrap and clear the abort
  localparam int DEFER_W = $clog2(DEFER_LIMIT + 2);
  logic [DEFER_W-1:0] defer_cnt_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      defer_cnt_reg <= '0;
      o_defer_abort <= 1'b0;
      o_backoff_slots <= '0;
    end else begin
      if (!i_deferring) begin
        defer_cnt_reg <= '0;
      end else if (link_rise && defer_cnt_reg <= DEFER_W'(DEFER_LIMIT)) begin
        defer_cnt_reg <= defer_cnt_reg + DEFER_W'(1);
      end
      o_defer_abort <= ctrl_reg[mac_csr_pkg::POS_DEFER_CHECK] && i_deferring &&
        defer_cnt_reg > DEFER_W'(DEFER_LIMIT);
      o_backoff_slots <= backoff_cnt_reg & backoff_mask;
    end
  end

  // Serial management frame: preamble, start, op, addresses, turn, data
  logic [2:0] mdio_sync_reg;
  logic mdio_in_reg;
  logic [$clog2(MDC_HALF + 1)-1:0] div_reg;
  logic [6:0] bit_cnt_reg;
  logic [63:0] frame_reg;
  logic mgmt_active_reg;
  logic mgmt_is_write_reg;
  logic mdc_tick;
  assign mdc_tick = div_reg == '0;
  assign mgmt_done = mgmt_active_reg && mdc_tick && o_mgmt_clk &&
    bit_cnt_reg == 7'(mac_csr_pkg::MGMT_FRAME_BITS - 1);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mdio_sync_reg <= '0;
      mdio_in_reg <= 1'b0;
    end else begin
      mdio_sync_reg <= {mdio_sync_reg[1:0], i_mgmt_data_in};
      if (mdio_sync_reg[1] == mdio_sync_reg[2]) begin
        mdio_in_reg <= mdio_sync_reg[2];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      div_reg <= '0;
      bit_cnt_reg <= '0;
      frame_reg <= '0;
      mgmt_active_reg <= 1'b0;
      mgmt_is_write_reg <= 1'b0;
      o_mgmt_clk <= 1'b0;
      o_mgmt_data_out <= 1'b0;
      o_mgmt_data_oe <= 1'b0;
    end else if (mgmt_launch) begin
      div_reg <= ($bits(div_reg))'(MDC_HALF - 1);
      bit_cnt_reg <= '0;
      mgmt_active_reg <= 1'b1;
      mgmt_is_write_reg <= cmd_out.data[mac_csr_pkg::POS_MGMT_WRITE];
      frame_reg <= {32'hFFFF_FFFF, 2'b01,
        cmd_out.data[mac_csr_pkg::POS_MGMT_WRITE] ? 2'b01 : 2'b10,
        cmd_out.data[mac_csr_pkg::POS_PHY_ADDR +: 5], cmd_out.data[mac_csr_pkg::POS_PHY_REG +: 5],
        2'b10, mgmt_data_reg[15:0]};
      o_mgmt_clk <= 1'b0;
      o_mgmt_data_out <= 1'b1;
      o_mgmt_data_oe <= 1'b1;
    end else if (mgmt_active_reg) begin
      div_reg <= mdc_tick ? ($bits(div_reg))'(MDC_HALF - 1) : div_reg - 1'b1;
      if (mdc_tick) begin
        o_mgmt_clk <= !o_mgmt_clk;
        if (o_mgmt_clk) begin
          // Falling edge: move to the next bit
          if (mgmt_done) begin
            mgmt_active_reg <= 1'b0;
            o_mgmt_data_oe <= 1'b0;
          end else begin
            bit_cnt_reg <= bit_cnt_reg + 7'h01;
            frame_reg <= {frame_reg[62:0], 1'b0};
            o_mgmt_data_out <= frame_reg[62];
            o_mgmt_data_oe <= mgmt_is_write_reg ||
              bit_cnt_reg < 7'(mac_csr_pkg::MGMT_TURN_BIT - 1);
          end
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      mgmt_data_reg <= '0;
    end else if (cmd_take && cmd_out.is_write && cmd_out.addr == mac_csr_pkg::OFS_MGMT_DATA) begin
      mgmt_data_reg <= cmd_out.data & mac_csr_pkg::MGMT_DATA_MASK;
    end else if (mgmt_active_reg && !mgmt_is_write_reg && mdc_tick && !o_mgmt_clk &&
      bit_cnt_reg >= 7'(mac_csr_pkg::MGMT_DATA_BIT)) begin
      mgmt_data_reg <= {16'h0000, mgmt_data_reg[14:0], mdio_in_reg};
    end
  end
endmodule // mac_csr_config

// [hdl/mac_csr_pkg.sv]
// Shared constants and carrier types for the MAC configuration register set
package mac_csr_pkg;
  localparam logic [3:0] CMD_CSR_WRITE = 4'h8;
  localparam logic [3:0] CMD_CSR_READ = 4'h9;

  localparam logic [7:0] OFS_MAC_CONTROL = 8'h00;
  localparam logic [7:0] OFS_STATION_HIGH = 8'h04;
  localparam logic [7:0] OFS_STATION_LOW = 8'h08;
  localparam logic [7:0] OFS_HASH_UPPER = 8'h0C;
  localparam logic [7:0] OFS_HASH_LOWER = 8'h10;
  localparam logic [7:0] OFS_MGMT_ADDR = 8'h14;
  localparam logic [7:0] OFS_MGMT_DATA = 8'h18;

  localparam int POS_PORT_TYPE = 27;
  localparam int POS_RX_OWN_DIS = 23;
  localparam int POS_LOOPBACK = 21;
  localparam int POS_FULL_DUPLEX = 20;
  localparam int POS_PASS_GROUP = 19;
  localparam int POS_ACCEPT_ALL = 18;
  localparam int POS_INVERSE = 17;
  localparam int POS_PASS_ERRORED = 16;
  localparam int POS_HASH_ONLY = 15;
  localparam int POS_HASH_EXACT = 13;
  localparam int POS_LATE_RETRY = 12;
  localparam int POS_BCAST_REJECT = 11;
  localparam int POS_RETRY_DIS = 10;
  localparam int POS_PAD_STRIP = 8;
  localparam int POS_BACKOFF_LIMIT = 6;
  localparam int POS_DEFER_CHECK = 5;
  localparam int POS_TX_ENABLE = 3;
  localparam int POS_RX_ENABLE = 2;
  localparam int POS_PHY_ADDR = 11;
  localparam int POS_PHY_REG = 6;
  localparam int POS_MGMT_WRITE = 1;
  localparam int POS_MGMT_BUSY = 0;

  localparam logic [31:0] CTRL_RESET = 32'h0004_0000;
  localparam logic [31:0] CTRL_MASK = 32'hD8FF_BDEC;
  localparam logic [31:0] STATION_HIGH_RESET = 32'h0000_FFFF;
  localparam logic [31:0] STATION_HIGH_MASK = 32'h0000_FFFF;
  localparam logic [31:0] STATION_LOW_RESET = 32'hFFFF_FFFF;
  localparam logic [31:0] HASH_RESET = 32'h0000_0000;
  localparam logic [31:0] MGMT_ADDR_MASK = 32'h0000_FFC2;
  localparam logic [31:0] MGMT_DATA_MASK = 32'h0000_FFFF;

  localparam logic [1:0] LOOPBACK_NORMAL = 2'h0;
  localparam logic [1:0] LOOPBACK_INTERNAL = 2'h1;
  localparam logic [1:0] LOOPBACK_EXTERNAL = 2'h2;
  localparam logic [1:0] BACKOFF_BITS_10 = 2'h0;
  localparam logic [1:0] BACKOFF_BITS_8 = 2'h1;
  localparam logic [1:0] BACKOFF_BITS_4 = 2'h2;

  localparam int CLK_PERIOD_NS = 40;
  localparam int BITS_PER_LINK_CLK = 4;
  localparam int SLOT_BITS = 512;
  localparam int SLOT_LINK_CLKS = SLOT_BITS / BITS_PER_LINK_CLK;
  localparam int DEFER_BIT_TIMES = 24288;
  localparam int DEFER_LINK_CLKS = DEFER_BIT_TIMES / BITS_PER_LINK_CLK;
  localparam int MDC_MIN_PERIOD_NS = 400;
  localparam int MDC_HALF_CLKS = (MDC_MIN_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MGMT_FRAME_BITS = 64;
  localparam int MGMT_TURN_BIT = 46;
  localparam int MGMT_DATA_BIT = 48;
  localparam logic [4:0] RETRY_ATTEMPTS_MAX = 5'h10;
  localparam logic [4:0] RETRY_ATTEMPTS_ONE = 5'h01;
  localparam logic [15:0] PAD_MIN_LEN = 16'h002E;

  typedef struct packed {
    logic is_write;
    logic [7:0] addr;
    logic [31:0] data;
  } csr_cmd_t;

  typedef struct packed {
    logic encoder_decoder_interface;
    logic receive_own_disable;
    logic [1:0] loopback_mode;
    logic full_duplex;
    logic late_collision_retry;
    logic transmit_enable;
    logic receive_enable;
  } mac_config_t;

  typedef struct packed {
    logic valid;
    logic [47:0] dest;
    logic [5:0] hash_index;
    logic errored;
    logic [15:0] length_field;
  } rx_frame_t;
endpackage

// [verif/mac_csr_config_checker.sv]
// Port-level assertions for the MAC configuration register block
module mac_csr_config_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_unit_cmd_wr,
  input wire logic [3:0] i_unit_cmd,
  input wire logic o_unit_cmd_ready,
  input wire logic o_unit_busy,
  input wire mac_csr_pkg::mac_config_t o_config,
  input wire mac_csr_pkg::rx_frame_t i_rx_frame,
  input wire logic i_tx_active,
  input wire logic o_rx_accept,
  input wire logic o_rx_strip_pad,
  input wire logic i_deferring,
  input wire logic o_defer_abort
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  a_busy_on_cmd: assert property (i_unit_cmd_wr && o_unit_cmd_ready && i_unit_cmd[3:1] == 3'h4
    |=> o_unit_busy) else $error("busy missing after command");
  a_ready_after_reset: assert property ($fell(i_rst) |-> !o_unit_cmd_ready ##1 o_unit_cmd_ready)
    else $error("ready timing after reset");
  a_busy_bounded: assert property ($rose(o_unit_busy) |-> ##[1:1000] !o_unit_busy)
    else $error("busy never cleared");
  a_accept_after_valid: assert property (o_rx_accept |-> $past(i_rx_frame.valid))
    else $error("accept without frame");
  a_rx_disabled_drop: assert property (i_rx_frame.valid && !o_config.receive_enable
    && $stable(o_config) |=> !o_rx_accept) else $error("frame taken while disabled");
  a_own_disable_drop: assert property (i_rx_frame.valid && i_tx_active
    && o_config.receive_own_disable |=> !o_rx_accept) else $error("own frame taken");
  a_defer_idle_clear: assert property (!i_deferring [*4] |-> !o_defer_abort)
    else $error("abort without deferral");
  a_strip_at_valid: assert property (!$past(i_rx_frame.valid) |-> $stable(o_rx_strip_pad))
    else $error("strip flag moved without frame");
endmodule // mac_csr_config_checker

bind mac_csr_config mac_csr_config_checker u_mac_csr_config_checker (.i_ref_clk, .i_rst,
  .i_unit_cmd_wr, .i_unit_cmd, .o_unit_cmd_ready, .o_unit_busy, .o_config, .i_rx_frame,
  .i_tx_active, .o_rx_accept, .o_rx_strip_pad, .i_deferring, .o_defer_abort);

// [verif/phy_mgmt_model.sv]
// Behavioural PHY answering on the two-wire management link
module phy_mgmt_model #(
  parameter logic [15:0] READ_WORD = 16'hC35A
) (
  input wire logic i_mdc,
  input wire logic i_oe,
  input wire logic i_mdio,
  output logic o_mdi,
  output logic [63:0] o_frame
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  logic is_rd = 1'b0;
  initial o_mdi = 1'b1;
  initial o_frame = '0;
  always @(posedge i_oe) idx = 0;
  always @(posedge i_mdc) begin
    o_frame <= {o_frame[62:0], i_mdio};
    if (idx == 36) is_rd <= (o_frame[1:0] == 2'b10);
    idx <= idx + 1;
  end
  // Released line floats to the pull-up level
  always @(negedge i_mdc) begin
    if (is_rd && idx >= 48 && idx < 64) o_mdi <= READ_WORD[63 - idx];
    else o_mdi <= 1'b1;
  end
endmodule // phy_mgmt_model

// [verif/ethernet_mac_csr_config_test.sv]
// Self-checking bench for the MAC configuration register block
module ethernet_mac_csr_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst = 1'b1, dwr = 1'b0, drd = 1'b0, awr = 1'b0, cwr = 1'b0, txa = 1'b0;
  logic lclk = 1'b0, dfr = 1'b0, oe, mdo, mdc, phy_mdi, mdi, rdy, busy, acc, fpass, strip, abort;
  logic [7:0] dwd = 8'h00, awd = 8'h00, rdata;
  logic [3:0] cmd = 4'h0;
  logic [4:0] lim;
  logic [9:0] bo;
  logic [31:0] q;
  logic [63:0] frame;
  mac_csr_pkg::rx_frame_t rxf = '0;
  mac_csr_pkg::mac_config_t cfg;
  int fail_count = 0, samples_checked = 0, cycles = 0;
  assign mdi = oe ? mdo : phy_mdi;
  mac_csr_config #(.DEFER_LIMIT(20)) u_mac_csr_config (.i_ref_clk(clk), .i_rst(rst),
    .i_data_port_wr(dwr), .i_data_port_wdata(dwd), .i_data_port_rd(drd),
    .o_data_port_rdata(rdata), .i_addr_port_wr(awr), .i_addr_port_wdata(awd),
    .i_unit_cmd_wr(cwr), .i_unit_cmd(cmd), .o_unit_cmd_ready(rdy), .o_unit_busy(busy),
    .o_config(cfg), .i_rx_frame(rxf), .i_tx_active(txa), .o_rx_accept(acc),
    .o_rx_filter_pass(fpass), .o_rx_strip_pad(strip), .i_link_clk(lclk), .i_deferring(dfr),
    .o_defer_abort(abort), .o_backoff_slots(bo), .o_attempt_limit(lim), .o_mgmt_clk(mdc),
    .o_mgmt_data_out(mdo), .o_mgmt_data_oe(oe), .i_mgmt_data_in(mdi));
  phy_mgmt_model u_phy_mgmt_model (.i_mdc(mdc), .i_oe(oe), .i_mdio(mdi), .o_mdi(phy_mdi),
    .o_frame(frame));
  initial forever #20 clk = ~clk;
  // Odd start offset keeps the link clock out of phase with the system clock
  initial begin
    #7;
    forever #160 lclk = ~lclk;
  end
  task automatic conclude;
    if (fail_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [63:0] g, input logic [63:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic access(input logic [3:0] c, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
    int n;
    for (n = 3; n >= 0; n--) @(posedge clk) {dwr, dwd} <= {c == 4'h8, d[8*n +: 8]};
    @(posedge clk) {dwr, awr, awd} <= {1'b0, 1'b1, a};
    @(posedge clk) {awr, cwr, cmd} <= {1'b0, 1'b1, c};
    @(posedge clk) cwr <= 1'b0;
    repeat (2) @(negedge clk);
    for (n = 0; busy !== 1'b0 && n < 2000; n++) @(negedge clk);
    check(n < 2000, 1'b1);
    for (n = 3; n >= 0; n--) begin
      r[8*n +: 8] = rdata;
      @(posedge clk) drd <= 1'b1;
      @(posedge clk) drd <= 1'b0;
      @(negedge clk);
    end
  endtask
  task automatic frame_in(input logic [47:0] dst, input logic [15:0] len, input logic tx,
      input logic [2:0] e);
    @(posedge clk) {rxf, txa} <= {1'b1, dst, 6'h00, 1'b0, len, tx};
    @(posedge clk) rxf.valid <= 1'b0;
    @(negedge clk);
    check({acc, fpass, strip}, e);
  endtask
  task automatic mgmt_wait;
    int n;
    n = 0;
    do access(4'h9, 8'h14, 32'h0, q);
    while (q[0] !== 1'b0 && ++n < 100);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    logic [7:0] addrs [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] rstv [8] = '{32'h0004_0000, 32'h0000_FFFF, 32'hFFFF_FFFF, 0, 0, 0, 0, 0};
    logic [31:0] onev [8] = '{32'hD8FF_BDEC, 32'h0000_FFFF, '1, '1, '1, 0, 32'h0000_FFFF, 0};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check({cfg, lim}, {8'h00, 5'h10});
    foreach (addrs[i]) begin
      access(4'h9, addrs[i], 32'h0, q);
      check(q, rstv[i]);
    end
    foreach (addrs[i]) begin
      if (i == 5) continue;
      access(4'h8, addrs[i], '1, q);
      access(4'h9, addrs[i], 32'h0, q);
      check(q, onev[i]);
    end
    check({cfg, lim, bo[9:1]}, {8'hFF, 5'h01, 9'h000});
    frame_in('1, 16'h0010, 1'b1, 3'b001);
    frame_in(48'h0200_0000_0001, 16'h002E, 1'b0, 3'b110);
    access(4'h8, 8'h00, 32'h0004_0004, q);
    frame_in('1, 16'h0010, 1'b1, 3'b110);
    access(4'h8, 8'h00, 32'h0000_0004, q);
    frame_in(48'h0200_0000_0001, 16'h0100, 1'b0, 3'b100);
    access(4'h8, 8'h00, 32'h0008_0004, q);
    frame_in(48'h0100_0000_0002, 16'h0100, 1'b0, 3'b110);
    access(4'h8, 8'h00, 32'h0000_0020, q);
    frame_in(48'h0200_0000_0001, 16'h0100, 1'b0, 3'b000);
    @(posedge clk) dfr <= 1'b1;
    repeat (300) @(posedge clk);
    check(abort, 1'b1);
    @(posedge clk) dfr <= 1'b0;
    repeat (8) @(posedge clk);
    check(abort, 1'b0);
    access(4'h8, 8'h18, 32'h0000_1234, q);
    access(4'h8, 8'h14, 32'h0000_54C2, q);
    access(4'h9, 8'h14, 32'h0, q);
    check(q, 32'h0000_54C3);
    // Writes to the data register stall behind the frame and back up the queue
    @(posedge clk) {awr, awd} <= {1'b1, 8'h18};
    @(posedge clk) {awr, cwr, cmd} <= {1'b0, 1'b1, 4'h8};
    repeat (18) @(posedge clk);
    check(rdy, 1'b0);
    @(posedge clk) cwr <= 1'b0;
    mgmt_wait();
    check(frame, {32'hFFFF_FFFF, 4'h5, 5'h0A, 5'h13, 2'b10, 16'h1234});
    access(4'h8, 8'h14, 32'h0000_54C0, q);
    mgmt_wait();
    access(4'h9, 8'h18, 32'h0, q);
    check(q, 32'h0000_C35A);
    conclude();
  end
endmodule // ethernet_mac_csr_config_test
